// ===== src/flash_prot_pkg.sv
// constants and types for the status and write-protection block
package flash_prot_pkg;

  // one-byte opcodes, most significant bit first on the wire
  localparam logic [7:0] OP_SET_LATCH    = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH    = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_WIPE  = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE   = 8'hc7;

  // status byte bit positions
  localparam int STAT_LOCK_POS = 7;
  localparam int STAT_BPHI_POS = 3;
  localparam int STAT_BPLO_POS = 2;
  localparam int STAT_WEL_POS  = 1;
  localparam int STAT_BUSY_POS = 0;

  // value of the non-volatile bits after reset: lock, bp_hi, bp_lo
  localparam logic [2:0] NV_RESET = 3'h0;

  // whole-byte counts: per accepted frame, counter saturation, last address byte
  localparam logic [2:0] BYTES_OPCODE_ONLY  = 3'h1;
  localparam logic [2:0] BYTES_STATUS_WRITE = 3'h2;
  localparam logic [2:0] BYTES_SECTOR_WIPE  = 3'h4;
  localparam logic [2:0] BYTES_PROGRAM_MIN  = 3'h5;
  localparam logic [2:0] BYTES_SATURATE     = 3'h7;
  localparam logic [2:0] BYTES_ADDR_LAST    = 3'h3;

  // sector select bits of the 24-bit address
  localparam int SECTOR_MSB = 16;
  localparam int SECTOR_LSB = 15;

  // self-timed cycle durations
  localparam int CLK_PERIOD_NS       = 10;
  localparam int T_STATUS_WRITE_NS   = 5000;
  localparam int T_PAGE_PROGRAM_NS   = 3000;
  localparam int T_SECTOR_WIPE_NS    = 8000;
  localparam int T_CHIP_ERASE_NS     = 12000;
  localparam int STATUS_WRITE_CYCLES =
    (T_STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_PROGRAM_CYCLES =
    (T_PAGE_PROGRAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SECTOR_WIPE_CYCLES  =
    (T_SECTOR_WIPE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHIP_ERASE_CYCLES   =
    (T_CHIP_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    CMD_NONE    = 3'b000,
    CMD_SET     = 3'b001,
    CMD_CLR     = 3'b010,
    CMD_READ    = 3'b011,
    CMD_WRITE   = 3'b100,
    CMD_PROGRAM = 3'b101,
    CMD_SECTOR  = 3'b110,
    CMD_CHIP    = 3'b111
  } cmd_t;

  typedef struct packed {
    logic       lock;
    logic [2:0] zero;
    logic       bp_hi;
    logic       bp_lo;
    logic       write_latch;
    logic       busy;
  } status_t;

  // what the serial side captured during one frame
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [2:0]  bytes;
    logic [2:0]  bits;
  } frame_t;

endpackage : flash_prot_pkg

// ===== src/bit_sync.sv
// two-flop synchroniser for independent levels
`timescale 1ns/100ps
module bit_sync
  import flash_prot_pkg::*;
#(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= RESET_VAL;
      q    <= RESET_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : bit_sync

// ===== src/cycle_timer.sv
// down-counter for the self-timed internal cycles
`timescale 1ns/100ps
module cycle_timer
  import flash_prot_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // control
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  output logic                  running
);

  logic [CNT_W-1:0] remain;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      remain <= '0;
    end else if (start && remain == '0) begin
      remain <= load;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  assign running = (remain != '0);

endmodule : cycle_timer

// ===== src/flash_status_protect.sv
// status byte, write latch and write protection behind the serial port
// Function
// RULE1: set-latch opcode sets write_latch.
// RULE2: program, erase and status write refused unless write_latch is 1.
// RULE3: host frames latch opcodes as select low, one byte, select high.
// RULE4: clear-latch opcode resets write_latch.
// RULE5: write_latch clears at reset and after clear, write, program, erase.
// RULE6: status read answers always, even during an internal cycle.
// RULE7: status byte repeats while select stays low after a read.
// RULE8: host should poll busy before new commands during a cycle.
// RULE9: busy_flag is 1 during write, program or erase cycles only.
// RULE10: lock and protect bits writable; latch and busy read-only.
// RULE11: protect bits change only outside hardware protected mode.
// RULE12: program and sector wipe refused inside the protected region.
// RULE13: lock set and pin low freeze protect bits, refuse status write.
// RULE14: status write needs exactly opcode plus one byte, else discarded.
// RULE15: status write keeps bits 6,5,4,1,0; bits 6..4 read zero.
// RULE16: accepted status write starts timed cycle; latch clears inside it.
// RULE17: lock bit 0 allows status write with latch, any pin level.
// RULE18: lock bit 1 allows status write only with the pin high.
// RULE19: protected mode whenever lock is 1 and pin low, any order.
// RULE20: protected mode ends only by raising the pin; reset also ends it here, as NV_RESET clears lock.
// RULE21: opcodes are eight bits, msb first, with the listed codes.
// RULE22: protect pair 00 none, 01 top quarter, 10 top half, 11 all.
// RULE23: chip erase runs only when both protect bits are 0.
// RULE24: write, program, erase need clock count a multiple of eight.
// RULE25: status layout lock b7, protect b3 b2, latch b1, busy b0.
`timescale 1ns/100ps
module flash_status_protect
  import flash_prot_pkg::*;
#(
  parameter int CNT_W        = 16,
  parameter int WRITE_CYCLES = STATUS_WRITE_CYCLES,
  parameter int PROG_CYCLES  = PAGE_PROGRAM_CYCLES,
  parameter int WIPE_CYCLES  = SECTOR_WIPE_CYCLES,
  parameter int ERASE_CYCLES = CHIP_ERASE_CYCLES
) (
  // system clock and reset
  input  wire logic       CLK,
  input  wire logic       RESETN,
  // serial port
  input  wire logic       SCLK,
  input  wire logic       CS_N,
  input  wire logic       MOSI,
  output logic            MISO,
  output logic            MISO_OE,
  // protect pin
  input  wire logic       WP_N,
  // observation
  output status_t         STATUS
);

  // ---------------- serial clock domain ----------------
  frame_t     frame;
  logic       first;
  logic       frame_tog;
  logic [2:0] cur_bits;
  logic [2:0] cur_bytes;
  logic [7:0] out_sr;
  logic       out_en;
  status_t    status_link;
  status_t    status;
  status_t    status_hold;
  logic       hand_req;
  logic       req_link;
  logic       hand_ack;
  logic       hand_ack_s;

  // high from deselect until the first clock of a frame
  always_ff @(posedge SCLK or posedge CS_N or negedge RESETN) begin
    if (!RESETN) begin
      first <= 1'b1;
    end else if (CS_N) begin
      first <= 1'b1;
    end else begin
      first <= 1'b0;
    end
  end

  assign cur_bits  = first ? 3'h0 : frame.bits;
  assign cur_bytes = first ? 3'h0 : frame.bytes;

  // marks a new frame for the system side
  always_ff @(posedge SCLK or negedge RESETN) begin
    if (!RESETN) begin
      frame_tog <= 1'b0;
    end else if (first) begin
      frame_tog <= ~frame_tog;
    end
  end

  // opcode, address or data bytes, counted in bits and whole bytes
  always_ff @(posedge SCLK or negedge RESETN) begin
    if (!RESETN) begin
      frame <= '0;
    end else begin
      frame.bits <= cur_bits + 3'h1;
      if (cur_bits == 3'h7 && cur_bytes != BYTES_SATURATE) begin
        frame.bytes <= cur_bytes + 3'h1; // RULE24
      end else begin
        frame.bytes <= cur_bytes;
      end
      if (cur_bytes == 3'h0) begin
        frame.opcode <= {(first ? 7'h00 : frame.opcode[6:0]), MOSI}; // RULE21
      end
      if (first) begin
        frame.addr <= '0;
      end else if (cur_bytes != 3'h0 && cur_bytes <= BYTES_ADDR_LAST) begin
        frame.addr <= {frame.addr[22:0], MOSI};
      end
    end
  end

  // status byte handed to the serial clock by a toggle handshake;
  // the held copy stays still while request and acknowledge differ
  bit_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_req_sync (
    .clk    (SCLK),
    .resetn (RESETN),
    .d      (hand_req),
    .q      (req_link)
  );

  // serial clock runs only inside frames: a change made between
  // frames lands within the first few clocks of the next one
  always_ff @(posedge SCLK or negedge RESETN) begin
    if (!RESETN) begin
      status_link <= '0;
      hand_ack    <= 1'b0;
    end else if (req_link != hand_ack) begin
      status_link <= status_hold;
      hand_ack    <= req_link;
    end
  end

  // output shifts on the falling edge, byte reloaded each boundary
  always_ff @(negedge SCLK or posedge CS_N or negedge RESETN) begin
    if (!RESETN) begin
      out_sr <= 8'h00;
      out_en <= 1'b0;
    end else if (CS_N) begin
      out_sr <= 8'h00;
      out_en <= 1'b0;
    end else if (!first && frame.bits == 3'h0 && frame.bytes != 3'h0 &&
                 frame.opcode == OP_STATUS_READ) begin
      out_sr <= status_link; // RULE6 RULE7
      out_en <= 1'b1;
    end else begin
      out_sr <= {out_sr[6:0], 1'b0};
    end
  end

  assign MISO    = out_sr[7];
  assign MISO_OE = out_en;

  // ---------------- system clock domain ----------------
  logic [2:0]       pins_s;
  logic             cs_s;
  logic             wp_s;
  logic             tog_s;
  logic             cs_prev;
  logic             tog_seen;
  logic             frame_end;
  logic             lock;
  logic             bp_hi;
  logic             bp_lo;
  logic             write_latch;
  logic             busy;
  logic             hw_prot;
  logic             byte_ok;
  logic             write_ok;
  logic             region_hit;
  logic [1:0]       sector;
  logic [7:0]       wr_data;
  cmd_t             cmd;
  logic             do_set;
  logic             do_clr;
  logic             do_write;
  logic             do_program;
  logic             do_sector;
  logic             do_chip;
  logic             start;
  logic [CNT_W-1:0] load;

  bit_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h6)
  ) u_pin_sync (
    .clk    (CLK),
    .resetn (RESETN),
    .d      ({CS_N, WP_N, frame_tog}),
    .q      (pins_s)
  );

  assign cs_s  = pins_s[2];
  assign wp_s  = pins_s[1];
  assign tog_s = pins_s[0];

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cs_prev  <= 1'b1;
      tog_seen <= 1'b0;
    end else begin
      cs_prev <= cs_s;
      if (frame_end) begin
        tog_seen <= tog_s;
      end
    end
  end

  // frame fields are still since the serial clock stopped before deselect
  assign frame_end = cs_s && !cs_prev && (tog_s != tog_seen);

  always_comb begin
    case (frame.opcode)
      OP_SET_LATCH:    cmd = CMD_SET;
      OP_CLR_LATCH:    cmd = CMD_CLR;
      OP_STATUS_READ:  cmd = CMD_READ;
      OP_STATUS_WRITE: cmd = CMD_WRITE;
      OP_PAGE_PROGRAM: cmd = CMD_PROGRAM;
      OP_SECTOR_WIPE:  cmd = CMD_SECTOR;
      OP_CHIP_ERASE:   cmd = CMD_CHIP;
      default:         cmd = CMD_NONE;
    endcase
  end

  assign hw_prot  = lock && !wp_s; // RULE19 RULE20 RULE13
  assign byte_ok  = (frame.bits == 3'h0); // RULE24
  assign write_ok = frame_end && write_latch && !busy && byte_ok; // RULE2
  assign sector   = frame.addr[SECTOR_MSB:SECTOR_LSB];
  assign wr_data  = frame.addr[7:0];

  always_comb begin
    case ({bp_hi, bp_lo})
      2'b00:   region_hit = 1'b0; // RULE22
      2'b01:   region_hit = (sector == 2'h3);
      2'b10:   region_hit = sector[1];
      default: region_hit = 1'b1;
    endcase
  end

  // commands other than status read are ignored while busy
  assign do_set     = frame_end && !busy && cmd == CMD_SET &&
                      frame.bytes != 3'h0; // RULE1
  assign do_clr     = frame_end && !busy && cmd == CMD_CLR &&
                      frame.bytes != 3'h0; // RULE4
  assign do_write   = write_ok && cmd == CMD_WRITE && !hw_prot &&
                      frame.bytes == BYTES_STATUS_WRITE; // RULE14 RULE17 RULE18
  assign do_program = write_ok && cmd == CMD_PROGRAM && !region_hit &&
                      frame.bytes >= BYTES_PROGRAM_MIN; // RULE12
  assign do_sector  = write_ok && cmd == CMD_SECTOR && !region_hit &&
                      frame.bytes == BYTES_SECTOR_WIPE; // RULE12
  assign do_chip    = write_ok && cmd == CMD_CHIP && !bp_hi && !bp_lo &&
                      frame.bytes == BYTES_OPCODE_ONLY; // RULE23

  assign start = do_write || do_program || do_sector || do_chip; // RULE16

  always_comb begin
    load = '0;
    if (do_write) begin
      load = CNT_W'(WRITE_CYCLES);
    end else if (do_program) begin
      load = CNT_W'(PROG_CYCLES);
    end else if (do_sector) begin
      load = CNT_W'(WIPE_CYCLES);
    end else if (do_chip) begin
      load = CNT_W'(ERASE_CYCLES);
    end
  end

  cycle_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .clk     (CLK),
    .resetn  (RESETN),
    .start   (start),
    .load    (load),
    .running (busy)
  );

  // latch cleared as each internal cycle starts, well before it ends
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      write_latch <= 1'b0; // RULE5
    end else if (do_set) begin
      write_latch <= 1'b1; // RULE1
    end else if (do_clr || start) begin
      write_latch <= 1'b0; // RULE4 RULE5 RULE16
    end
  end

  // non-volatile bits, only the status write touches them
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      {lock, bp_hi, bp_lo} <= NV_RESET;
    end else if (do_write) begin
      lock  <= wr_data[STAT_LOCK_POS]; // RULE10 RULE11
      bp_hi <= wr_data[STAT_BPHI_POS];
      bp_lo <= wr_data[STAT_BPLO_POS]; // RULE15
    end
  end

  always_comb begin
    status       = '0; // RULE15
    status.lock  = lock; // RULE25
    status.bp_hi = bp_hi;
    status.bp_lo = bp_lo;
    status.write_latch   = write_latch;
    status.busy  = busy; // RULE9
  end

  // a new copy is offered only once the last one has been taken
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      status_hold <= '0;
      hand_req    <= 1'b0;
    end else if (hand_req == hand_ack_s && status_hold != status) begin
      status_hold <= status;
      hand_req    <= ~hand_req;
    end
  end

  bit_sync #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_ack_sync (
    .clk    (CLK),
    .resetn (RESETN),
    .d      (hand_ack),
    .q      (hand_ack_s)
  );

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      STATUS <= '0;
    end else begin
      STATUS <= status;
    end
  end

endmodule : flash_status_protect

// ===== verification/flash_prot_asserts.sv
// port assertions for the status and protection block
`timescale 1ns/100ps
module flash_prot_asserts
  import flash_prot_pkg::*;
#(
  parameter int WRITE_CYCLES = 5,
  parameter int PROG_CYCLES  = 5,
  parameter int WIPE_CYCLES  = 5,
  parameter int ERASE_CYCLES = 5
) (
  // clocks and reset
  input wire logic    CLK,
  input wire logic    RESETN,
  input wire logic    SCLK,
  // serial port and pin
  input wire logic    CS_N,
  input wire logic    MOSI,
  input wire logic    MISO,
  input wire logic    MISO_OE,
  input wire logic    WP_N,
  // observation
  input wire status_t STATUS
);
  int         busy_len;
  logic [2:0] nv;
  assign nv = {STATUS.lock, STATUS.bp_hi, STATUS.bp_lo};
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) busy_len <= 0;
    else busy_len <= STATUS.busy ? busy_len + 1 : 0;
  end
  zero_bits_a: assert property (STATUS.zero == 3'h0)
    else $error("status bits 6 to 4 not zero");
  oe_idle_a: assert property (CS_N |-> !MISO_OE)
    else $error("data out enabled while deselected");
  wel_set_a: assert property ($rose(STATUS.write_latch) |-> CS_N && $past(CS_N, 3))
    else $error("latch set without a finished frame");
  busy_start_a: assert property ($rose(STATUS.busy) |-> $fell(STATUS.write_latch))
    else $error("cycle started without clearing latch");
  busy_hold_a: assert property (
    STATUS.busy && $past(STATUS.busy) |-> !$rose(STATUS.write_latch))
    else $error("latch set during an internal cycle");
  busy_len_a: assert property ($fell(STATUS.busy) |-> busy_len inside
    {WRITE_CYCLES, PROG_CYCLES, WIPE_CYCLES, ERASE_CYCLES})
    else $error("internal cycle of wrong length");
  nv_change_a: assert property ($changed(nv) |-> $rose(STATUS.busy))
    else $error("protect bits changed outside a write");
  hw_lock_a: assert property (
    $past(STATUS.lock) && !WP_N && !$past(WP_N, 8) |-> $stable(nv))
    else $error("protect bits changed while pin locked");
  cov_busy: cover property ($rose(STATUS.busy));
  cov_read: cover property ($rose(MISO_OE));
  cov_hpm: cover property (STATUS.lock && !WP_N);
endmodule : flash_prot_asserts
bind flash_status_protect flash_prot_asserts #(
  .WRITE_CYCLES(WRITE_CYCLES), .PROG_CYCLES(PROG_CYCLES),
  .WIPE_CYCLES(WIPE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)
) chk (
  .CLK(CLK), .RESETN(RESETN), .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI),
  .MISO(MISO), .MISO_OE(MISO_OE), .WP_N(WP_N), .STATUS(STATUS)
);

// ===== verification/spi_host_model.sv
// serial host model that frames commands, clock idle low
`timescale 1ns/100ps
module spi_host_model (
  // serial lines
  output logic      SCLK,
  output logic      CS_N,
  output logic      MOSI,
  input  wire logic MISO
);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    MOSI = 1'b0;
  end
  // n clocks, msb first, 30 ns period
  task automatic xfer(input int n, input logic [39:0] d,
                      output logic [15:0] rx);
    #3 CS_N = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      MOSI = d[i];
      #15 SCLK = 1'b1;
      rx = {rx[14:0], MISO};
      #15 SCLK = 1'b0;
    end
    #15 CS_N = 1'b1;
    MOSI = ~MOSI;
    #60;
  endtask : xfer
endmodule : spi_host_model

// ===== verification/testbench.sv
// self-checking bench for the status and protection block
`timescale 1ns/100ps
module testbench;
  import flash_prot_pkg::*;
  logic        CLK = 1'b1;
  logic        RESETN = 1'b1;
  logic        WP_N = 1'b1;
  wire logic   SCLK, CS_N, MOSI, MISO, MISO_OE;
  status_t     STATUS;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          lock = 0, bp = 0, write_latch = 0, busy = 0;
  int          lim[4] = '{4, 3, 2, 0};
  logic [31:0] rnd = 32'hf599;
  logic [15:0] rx;
  always #5 CLK = ~CLK;
  flash_status_protect #(.WRITE_CYCLES(200), .PROG_CYCLES(100),
    .WIPE_CYCLES(120), .ERASE_CYCLES(150)) dut (
    .CLK(CLK), .RESETN(RESETN), .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI),
    .MISO(MISO), .MISO_OE(MISO_OE), .WP_N(WP_N), .STATUS(STATUS));
  spi_host_model host (.SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] expv();
    return {lock[0], 3'h0, bp[1:0], write_latch[0], busy[0]};
  endfunction : expv
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // send one frame, update the model, compare the status
  task automatic cmd(input int n, input logic [39:0] d);
    logic [7:0] op;
    int         sec;
    op = 8'(d >> (n - 8));
    sec = (n == 40) ? int'(d[24:23]) : int'(d[16:15]);
    host.xfer(n, d, rx);
    if (busy == 0) begin
      case (op)
        OP_SET_LATCH: write_latch = 1;
        OP_CLR_LATCH: write_latch = 0;
        OP_STATUS_WRITE: if (write_latch && n == 16 && !(lock && !WP_N)) begin
          lock = d[7];
          bp = d[3:2];
          write_latch = 0;
          busy = 1;
        end
        OP_PAGE_PROGRAM, OP_SECTOR_WIPE: begin
          if (write_latch && n == (op == OP_SECTOR_WIPE ? 32 : 40)
              && sec < lim[bp]) begin
            write_latch = 0;
            busy = 1;
          end
        end
        OP_CHIP_ERASE: if (write_latch && n == 8 && bp == 0) begin
          write_latch = 0;
          busy = 1;
        end
        default: ;
      endcase
    end
    repeat (4) @(negedge CLK);
    chk(STATUS, expv());
  endtask : cmd
  task automatic settle();
    int k;
    k = 0;
    while (STATUS.busy !== 1'b0 && k < 400) begin
      @(negedge CLK);
      k++;
    end
    busy = 0;
    chk(STATUS, expv());
  endtask : settle
  task automatic rd();
    logic [7:0] e;
    e = expv();
    cmd(24, 40'h050000);
    chk(rx[15:8], e);
    chk(rx[7:0], e);
  endtask : rd
  initial begin
    @(negedge CLK);
    RESETN = 1'b0;
    repeat (6) @(negedge CLK);
    RESETN = 1'b1;
    repeat (3) @(negedge CLK);
    chk(STATUS, expv());
    cmd(8, 40'h06);
    cmd(8, 40'h04);
    cmd(16, {24'h0, 8'h01, rnd[7:0]});
    $display("test latch done");
    rnd = lfsr(rnd);
    cmd(8, 40'h06);
    cmd(16, {24'h0, 8'h01, rnd[7:0] & 8'h7f});
    rd();
    cmd(8, 40'h06);
    settle();
    cmd(8, 40'h06);
    cmd(15, 40'h0080);
    cmd(17, 40'h0200);
    $display("test write done");
    WP_N = 1'b0;
    cmd(16, 40'h0184);
    settle();
    cmd(8, 40'h06);
    cmd(16, 40'h0100);
    cmd(40, {8'h02, 24'h018000, 8'h5a});
    cmd(32, {8'h00, 8'hd8, 24'h010000});
    settle();
    WP_N = 1'b1;
    cmd(8, 40'h06);
    cmd(16, 40'h010c);
    settle();
    cmd(8, 40'h06);
    cmd(8, 40'hc7);
    cmd(32, {8'h00, 8'hd8, 24'h000000});
    cmd(16, 40'h0100);
    settle();
    cmd(8, 40'h06);
    cmd(8, 40'hc7);
    settle();
    rnd = lfsr(rnd);
    cmd(8, 40'h06);
    cmd(40, {8'h02, rnd});
    settle();
    cmd(8, 40'h06);
    cmd(16, 40'h0108);
    settle();
    cmd(8, 40'h06);
    cmd(40, {8'h02, 24'h010000, 8'ha5});
    cmd(40, {8'h02, 24'h008000, 8'ha5});
    settle();
    $display("test protect done");
    tally_and_finish();
  end
  // whole run is near 32 us, ample margin
  initial begin
    #500000;
    bad_count++;
    tally_and_finish();
  end
endmodule : testbench
